// ---- rtl/strap_cfg_pkg.sv ----
package strap_cfg_pkg;

   // widths of the management register port
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;

   // strap pins, packed as they are sampled
   typedef struct packed {
      logic [3:0] op_code;
      logic [2:0] station_address_strap;
      logic       ref_clock_out_enable;
      logic       indicator_style_select;
   } strap_s;

   // auto-negotiation advertisement set
   typedef struct packed {
      logic g_fd;
      logic g_hd;
      logic f_fd;
      logic f_hd;
      logic t_fd;
      logic t_hd;
   } adv_s;

   typedef enum {OP_RESERVED, OP_NAND_TREE, OP_POWER_DOWN, OP_RGMII} op_mode_e;

   // operating-mode codes
   localparam logic [3:0] CODE_NAND_TREE  = 4'h4;
   localparam logic [3:0] CODE_POWER_DOWN = 4'h7;
   localparam logic [3:0] CODE_RGMII_GFD  = 4'hC;
   localparam logic [3:0] CODE_RGMII_GALL = 4'hD;
   localparam logic [3:0] CODE_RGMII_NOGH = 4'hE;
   localparam logic [3:0] CODE_RGMII_ALL  = 4'hF;

   // upper management address bits
   localparam logic [1:0] ADDR_HIGH_BITS = 2'h0;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_STRAP = 5'h10;
   localparam logic [ADDR_W-1:0] REG_MODE  = 5'h11;
   localparam logic [ADDR_W-1:0] REG_OVR   = 5'h12;

   // override register fields
   localparam int OVR_EN_BIT     = 0;
   localparam int OVR_ADV_LSB    = 1;
   localparam int OVR_LED_BIT    = 7;
   localparam int OVR_REFCLK_BIT = 8;

   // mode register fields
   localparam int MODE_ADV_LSB    = 0;
   localparam int MODE_RGMII_BIT  = 6;
   localparam int MODE_NAND_BIT   = 7;
   localparam int MODE_PDOWN_BIT  = 8;
   localparam int MODE_RSVD_BIT   = 9;
   localparam int MODE_LED_BIT    = 10;
   localparam int MODE_REFCLK_BIT = 11;
   localparam int MODE_VALID_BIT  = 12;

   // strap register fields
   localparam int STRAP_RAW_LSB  = 0;
   localparam int STRAP_ADDR_LSB = 9;

   // reset values and capture timing
   localparam logic [DATA_W-1:0] OVR_RST       = 16'h0000;
   localparam strap_s            STRAP_RST     = '0;
   localparam logic [1:0]        SETTLE_CYCLES = 2'h2;

   function automatic op_mode_e decode_mode(input logic [3:0] code);
      op_mode_e m;
      m = OP_RESERVED;
      if (code == CODE_NAND_TREE) begin
         m = OP_NAND_TREE;
      end else if (code == CODE_POWER_DOWN) begin
         m = OP_POWER_DOWN;
      end else if (code[3:2] == 2'h3) begin
         m = OP_RGMII;
      end
      return m;
   endfunction

   function automatic adv_s decode_adv(input logic [3:0] code);
      adv_s a;
      a = '0;
      unique case (code)
         CODE_RGMII_GFD:  a = 6'h20;
         CODE_RGMII_GALL: a = 6'h30;
         CODE_RGMII_NOGH: a = 6'h2F;
         CODE_RGMII_ALL:  a = 6'h3F;
         default:         a = '0;
      endcase
      return a;
   endfunction

endpackage

// ---- rtl/strap_config_latch.sv ----
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module strap_config_latch (
   // clock and reset
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_n_in,
   // strap pins
   input  wire strap_cfg_pkg::strap_s           strap_pins_in,
   // management register port
   input  wire logic [strap_cfg_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [strap_cfg_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                            reg_wr_in,
   input  wire logic                            reg_rd_in,
   output logic      [strap_cfg_pkg::DATA_W-1:0] reg_rdata_out,
   // decoded configuration
   output logic      [4:0]                      station_address_out,
   output logic                                 config_valid_out,
   output logic                                 nand_tree_out,
   output logic                                 power_down_out,
   output logic                                 rgmii_out,
   output logic                                 reserved_code_out,
   output strap_cfg_pkg::adv_s                  adv_out,
   output logic                                 ref_clock_out_enable_out,
   output logic                                 single_indicator_style_select_out
);
   import strap_cfg_pkg::*;

   strap_s                  sync1_q;
   strap_s                  sync2_q;
   strap_s                  captured_q;
   logic   [1:0]            settle_q;
   logic                    valid_q;
   logic   [DATA_W-1:0]     ovr_q;
   logic   [DATA_W-1:0]     rdata_q;
   logic   [3:0]            code_w;
   op_mode_e                mode_w;
   adv_s                    adv_d;
   logic                    led_d;
   logic                    refclk_d;
   logic                    ovr_en_w;
   logic   [DATA_W-1:0]     mode_reg_w;
   logic   [DATA_W-1:0]     strap_reg_w;

   ////////////////////////////////////////////////////////////////////////////
   // strap synchroniser; board levels are not tied to our clock
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= STRAP_RST;
         sync2_q <= STRAP_RST;
      end else begin
         sync1_q <= strap_pins_in;
         sync2_q <= sync1_q;
      end
   end

   // capture once the synchroniser holds post-release levels
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         settle_q   <= '0;
         valid_q    <= 1'b0;
         captured_q <= STRAP_RST;
      end else begin
         if (settle_q != SETTLE_CYCLES) begin
            settle_q <= settle_q + 2'h1;
         end
         if (settle_q == SETTLE_CYCLES && !valid_q) begin
            captured_q <= sync2_q;
            valid_q    <= 1'b1;
         end
         // no other path updates captured_q, so later pin changes are ignored
      end
   end

   a_capture_value: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(valid_q) |-> captured_q == $past(sync2_q))
      else $error("captured straps differ from synchronised pins");

   a_capture_timing: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(valid_q) |-> $past(settle_q) == SETTLE_CYCLES && $past(settle_q, 2) == 2'h1)
      else $error("strap capture at wrong cycle after reset");

   a_capture_stable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      valid_q && $past(valid_q) |-> $stable(captured_q))
      else $error("captured straps changed without reset");

   ////////////////////////////////////////////////////////////////////////////
   // override register; software can replace the strap-derived advertisement, indicator and reference-clock settings
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ovr_q <= OVR_RST;
      end else if (reg_wr_in && reg_addr_in == REG_OVR) begin
         ovr_q <= reg_wdata_in;
      end
   end

   a_ovr_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_wr_in && reg_addr_in == REG_OVR |=> ovr_q == $past(reg_wdata_in))
      else $error("override register not written");

   a_ovr_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == REG_OVR |=> reg_rdata_out == $past(ovr_q))
      else $error("override register read back wrong");

   ////////////////////////////////////////////////////////////////////////////
   // decode and effective settings
   assign code_w   = captured_q.op_code;
   assign mode_w   = decode_mode(code_w);
   assign ovr_en_w = ovr_q[OVR_EN_BIT];

   always_comb begin
      adv_d    = decode_adv(code_w);
      led_d    = captured_q.indicator_style_select;
      refclk_d = captured_q.ref_clock_out_enable;
      if (ovr_en_w) begin
         adv_d    = ovr_q[OVR_ADV_LSB +: 6];
         led_d    = ovr_q[OVR_LED_BIT];
         refclk_d = ovr_q[OVR_REFCLK_BIT];
      end
      if (mode_w != OP_RGMII) begin
         adv_d = '0;
      end
   end

   // outputs stay quiet until the straps are in
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         config_valid_out         <= 1'b0;
         nand_tree_out            <= 1'b0;
         power_down_out           <= 1'b0;
         rgmii_out                <= 1'b0;
         reserved_code_out        <= 1'b0;
         adv_out                  <= '0;
         ref_clock_out_enable_out <= 1'b0;
         single_indicator_style_select_out      <= 1'b0;
         station_address_out      <= '0;
      end else begin
         config_valid_out         <= valid_q;
         nand_tree_out            <= valid_q && mode_w == OP_NAND_TREE;
         power_down_out           <= valid_q && mode_w == OP_POWER_DOWN;
         rgmii_out                <= valid_q && mode_w == OP_RGMII;
         reserved_code_out        <= valid_q && mode_w == OP_RESERVED;
         adv_out                  <= valid_q ? adv_d : '0;
         ref_clock_out_enable_out <= valid_q && refclk_d;
         single_indicator_style_select_out      <= valid_q && led_d;
         station_address_out      <= valid_q ? {ADDR_HIGH_BITS, captured_q.station_address_strap} : '0;
      end
   end

   a_mode_decode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(valid_q) |-> nand_tree_out == ($past(code_w) == CODE_NAND_TREE)
                      && power_down_out == ($past(code_w) == CODE_POWER_DOWN)
                      && rgmii_out == ($past(code_w[3:2]) == 2'h3))
      else $error("mode decode wrong");

   a_adv_decode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(valid_q) && !$past(ovr_en_w) && rgmii_out |-> adv_out == decode_adv($past(code_w)))
      else $error("advertisement set wrong");

   a_refclk_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(valid_q) && !$past(ovr_en_w)
      |-> ref_clock_out_enable_out == $past(captured_q.ref_clock_out_enable))
      else $error("reference clock enable does not follow strap");

   a_led_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(valid_q) && !$past(ovr_en_w)
      |-> single_indicator_style_select_out == $past(captured_q.indicator_style_select))
      else $error("indicator mode does not follow strap");

   a_station_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      valid_q |=> station_address_out[4:3] == ADDR_HIGH_BITS
               && station_address_out[2:0] == $past(captured_q.station_address_strap))
      else $error("management address wrong");

   a_quiet_before_valid: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !valid_q |=> !config_valid_out && !nand_tree_out && !power_down_out && !rgmii_out
                && !reserved_code_out && adv_out == '0 && station_address_out == '0)
      else $error("outputs active before straps captured");

   a_reserved_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(valid_q) |-> reserved_code_out == !(nand_tree_out || power_down_out || rgmii_out))
      else $error("reserved flag disagrees with mode outputs");

   a_adv_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !rgmii_out |-> adv_out == '0)
      else $error("advertisement set outside RGMII mode");

   ////////////////////////////////////////////////////////////////////////////
   // register read path; unmapped offsets read zero
   assign strap_reg_w = {2'h0, ADDR_HIGH_BITS, captured_q.station_address_strap, captured_q};
   assign mode_reg_w  = {3'h0, valid_q, refclk_d, led_d, mode_w == OP_RESERVED,
                         mode_w == OP_POWER_DOWN, mode_w == OP_NAND_TREE, mode_w == OP_RGMII, adv_d};

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= '0;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_STRAP: rdata_q <= strap_reg_w;
            REG_MODE:  rdata_q <= mode_reg_w;
            REG_OVR:   rdata_q <= ovr_q;
            default:   rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata_out = rdata_q;

   // read data stands one cycle only, so an idle bus must read zero
   a_read_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data not cleared");

   a_strap_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == REG_STRAP
      |=> reg_rdata_out[STRAP_ADDR_LSB +: 5] == {ADDR_HIGH_BITS, $past(captured_q.station_address_strap)})
      else $error("strap register address field wrong");

endmodule

// ---- tb/strap_board_model.sv ----
`timescale 1ns/100ps
module strap_board_model (
   // clock
   input  wire logic                  core_clk_in,
   // jumper settings and reset button
   input  wire strap_cfg_pkg::strap_s jumper_in,
   input  wire logic                  press_in,
   // lines seen by the device
   output strap_cfg_pkg::strap_s      strap_pins_out,
   output logic                       rst_n_out
);
   import strap_cfg_pkg::*;
   // power-up holds reset 10 cycles, the button 3
   logic [3:0] hold_q = 4'hA;
   ////////////////////////////////////////////////////////////////
   // resistors drive steady levels, so pins simply follow jumpers
   assign strap_pins_out = jumper_in;
   assign rst_n_out      = (hold_q == 4'h0);
   always @(posedge core_clk_in) begin
      if (press_in) begin
         hold_q <= 4'h3;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import strap_cfg_pkg::*;
   logic core_clk, rst_n, press, wr, rd;
   strap_s jumper, pins, s;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d, ov;
   logic [4:0] sta;
   logic valid, nand_t, pdown, rgm, rsvd, refc, led;
   adv_s adv;
   logic [17:0] e;
   logic [31:0] lfsr;
   logic [3:0] code_tab [6] = '{4'h4, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
   int bad_count, n_checks;
   ////////////////////////////////////////////////////////////////
   strap_board_model i_strap_board_model (.core_clk_in(core_clk), .jumper_in(jumper), .press_in(press),
      .strap_pins_out(pins), .rst_n_out(rst_n));
   strap_config_latch i_strap_config_latch (.core_clk_in(core_clk), .rst_n_in(rst_n), .strap_pins_in(pins),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .station_address_out(sta), .config_valid_out(valid), .nand_tree_out(nand_t), .power_down_out(pdown),
      .rgmii_out(rgm), .reserved_code_out(rsvd), .adv_out(adv), .ref_clock_out_enable_out(refc),
      .single_indicator_style_select_out(led));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // {addr5, valid, nand, pdown, rgmii, rsvd, adv6, refclk, led}
   function automatic logic [17:0] exp_out(strap_s x, logic o, logic [5:0] a, logic l, logic r);
      logic [5:0] t;
      logic g;
      g = (x.op_code[3:2] == 2'h3);
      case (x.op_code)
         4'hC: t = 6'h20;
         4'hD: t = 6'h30;
         4'hE: t = 6'h2F;
         4'hF: t = 6'h3F;
         default: t = 6'h00;
      endcase
      if (o) t = g ? a : 6'h00;
      return {2'h0, x.station_address_strap, 1'b1, x.op_code == 4'h4, x.op_code == 4'h7, g, 1'b0, t,
              o ? r : x.ref_clock_out_enable, o ? l : x.indicator_style_select};
   endfunction
   task automatic chk_out(logic [17:0] x);
      n_checks++;
      if ({sta, valid, nand_t, pdown, rgm, rsvd, adv, refc, led} !== x) begin
         bad_count++;
         $display("[ERR] %0t outputs %h expected %h", $time, {sta, valid, nand_t, pdown, rgm, rsvd, adv,
            refc, led}, x);
      end
   endtask
   task automatic chk_reg(logic [15:0] g, logic [15:0] x);
      n_checks++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t register read %h expected %h", $time, g, x);
      end
   endtask
   task automatic rd_reg(logic [4:0] a, output logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wr_reg(logic [4:0] a, logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
   initial begin
      lfsr = 32'h00010501;
      {press, wr, rd, addr, wdata, jumper} = '0;
      bad_count = 0;
      n_checks = 0;
      repeat (12) @(posedge core_clk);
      for (int k = 0; k < 6; k++) begin
         void'(rnd());
         s = lfsr[8:0];
         s.op_code = code_tab[k];
         s.ref_clock_out_enable = k[0];
         @(posedge core_clk);
         jumper <= s;
         press <= 1'b1;
         @(posedge core_clk);
         press <= 1'b0;
         repeat (10) @(posedge core_clk);
         #1 e = exp_out(s, 1'b0, 6'h00, 1'b0, 1'b0);
         chk_out(e);
         @(posedge core_clk);
         jumper <= {code_tab[5 - k], ~s[4:0]};
         repeat (5) @(posedge core_clk);
         #1 chk_out(e);
         rd_reg(REG_MODE, d);
         chk_reg(d, {3'h0, e[12], e[1], e[0], e[8], e[10], e[11], e[9], e[7:2]});
         rd_reg(REG_STRAP, d);
         chk_reg(d, {4'h0, s.station_address_strap, s});
         void'(rnd());
         ov = lfsr[15:0];
         ov[0] = 1'b1;
         wr_reg(REG_OVR, ov);
         @(posedge core_clk);
         #1 chk_out(exp_out(s, 1'b1, ov[6:1], ov[7], ov[8]));
         rd_reg(REG_OVR, d);
         chk_reg(d, ov);
         rd_reg(5'h1F, d);
         chk_reg(d, 16'h0000);
         wr_reg(REG_STRAP, 16'hFFFF);
         wr_reg(REG_OVR, 16'h0000);
         rd_reg(REG_STRAP, d);
         chk_reg(d, {4'h0, s.station_address_strap, s});
         #1 chk_out(e);
         $display("test code %h done", s.op_code);
      end
      close_out();
   end
endmodule
